// ==== flag_bank_pkg.sv ====
package flag_bank_pkg;

  // Register addresses of the read-only words
  localparam logic [15:0] ADDR_STATUS = 16'h003a;
  localparam logic [15:0] ADDR_ALARM1 = 16'h003b;
  localparam logic [15:0] ADDR_ALARM2 = 16'h003c;
  localparam logic [15:0] ADDR_ALARM3 = 16'h003d;
  localparam logic [15:0] ADDR_ALARM5 = 16'h003f;

  // Reset value of every word
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Status word bit positions
  localparam int ST_RUN = 0;
  localparam int ST_STOP_ALARM = 1;
  localparam int ST_CONT_ALARM = 2;
  localparam int ST_TEMP_READY = 4;
  localparam int ST_ANTI_FREEZE = 15;

  // Alarm word 1 bit positions
  localparam int A1_LOW_TANK = 0;
  localparam int A1_HIGH_FLUID_TEMP = 1;
  localparam int A1_HIGH_RETURN_TEMP = 4;
  localparam int A1_HIGH_DISCH_PRESS = 5;
  localparam int A1_DISCH_PRESS_RISE = 7;
  localparam int A1_DISCH_PRESS_DROP = 8;
  localparam int A1_LOW_SUCTION_TEMP = 10;
  localparam int A1_HS_PRESS_RISE = 12;
  localparam int A1_REFRIG_LEAK = 14;
  localparam int A1_LS_PRESS_RISE = 15;

  // Alarm word 2 bit positions
  localparam int A2_LS_PRESS_DROP = 0;
  localparam int A2_COMP_FAIL = 1;
  localparam int A2_COMM_ERROR = 2;
  localparam int A2_SENSOR_BASE = 5;
  localparam int SENSOR_COUNT = 6;
  localparam int A2_CONTACT1 = 14;
  localparam int A2_CONTACT2 = 15;

  // Live status conditions from the plant controller
  typedef struct packed {
    logic anti_freeze;
    logic temp_ready;
    logic cont_alarm;
    logic stop_alarm;
    logic running;
  } status_cond_t;

  // Live alarm conditions; sensor_fail order: discharge_temp_sensor_ch1,
  // return_temp_sensor, suction_temp_sensor, discharge_pressure_sensor,
  // high_side_pressure_sensor, low_side_pressure_sensor (bit 0 first)
  typedef struct packed {
    logic contact2;
    logic contact1;
    logic [5:0] sensor_fail;
    logic comm_error;
    logic comp_fail;
    logic ls_press_drop;
    logic ls_press_rise;
    logic refrig_leak;
    logic hs_press_rise;
    logic low_suction_temp;
    logic disch_press_drop;
    logic disch_press_rise;
    logic high_disch_press;
    logic high_return_temp;
    logic high_fluid_temp;
    logic low_tank;
  } alarm_cond_t;

endpackage : flag_bank_pkg

// ==== flag_word_reg.sv ====
`timescale 1ns/10ps
// One 16-bit flag word that follows its mapped conditions each clock
module flag_word_reg (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] word_next,
  output logic [15:0] word_reg
);

  // Plain capture; a read never touches it, so flags are not cleared
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word_reg <= flag_bank_pkg::WORD_RESET;
    end else begin
      word_reg <= word_next;
    end
  end

endmodule : flag_word_reg

// ==== status_alarm_flag_bank.sv ====
`timescale 1ns/10ps
module status_alarm_flag_bank (
  input wire logic clk,
  input wire logic reset_n,
  input wire flag_bank_pkg::status_cond_t status_cond,
  input wire flag_bank_pkg::alarm_cond_t alarm_cond,
  input wire logic rd_strobe,
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_addr_error
);

  // Populated words: status, alarm word 1 and alarm word 2, address order
  localparam int WORD_COUNT =
    int'(flag_bank_pkg::ADDR_ALARM2 - flag_bank_pkg::ADDR_STATUS) + 1;

  // Mapped next values of the three populated words
  logic [15:0] status_next; // Status word before its register
  logic [15:0] alarm1_next; // Alarm word 1 before its register
  logic [15:0] alarm2_next; // Alarm word 2 before its register
  // Next values and stored words, one entry per populated word
  logic [15:0] word_next_arr [WORD_COUNT];
  logic [15:0] word_arr [WORD_COUNT];
  // Stored words under their register names
  logic [15:0] product_status_word; // Read at the status address
  logic [15:0] alarm_word_one; // First alarm word
  logic [15:0] alarm_word_two; // Second alarm word
  // Read mux result
  logic [15:0] rd_data_next; // Word picked by the current address
  logic rd_hit; // Address falls inside the mapped range

  // Status mapping. Only bits 0, 1, 2, 4 and 15 carry meaning; every
  // other bit is tied to zero, so a host that masks nothing still sees
  // a clean word. The conditions are levels that already live in this
  // clock domain, so no synchroniser stands in front of them.
  always_comb begin
    // Start from all zero so unnamed bits never float
    status_next = 16'h0000;

    // Unit running rather than stopped
    status_next[flag_bank_pkg::ST_RUN] = status_cond.running;

    // An alarm that halts the unit is up
    status_next[flag_bank_pkg::ST_STOP_ALARM] =
      status_cond.stop_alarm;

    // An alarm is up but the unit keeps running
    status_next[flag_bank_pkg::ST_CONT_ALARM] =
      status_cond.cont_alarm;

    // Fluid temperature has reached its ready window
    status_next[flag_bank_pkg::ST_TEMP_READY] =
      status_cond.temp_ready;

    // Anti-freeze setting in force
    status_next[flag_bank_pkg::ST_ANTI_FREEZE] =
      status_cond.anti_freeze;
  end

  // Alarm word 1 mapping, one bit per alarm type. Bits 2, 3, 6, 9, 11
  // and 13 are reserved and read zero. Each bit is a live level, not a
  // latch: it drops as soon as the controller withdraws the condition.
  always_comb begin
    // Start from all zero so reserved bits never float
    alarm1_next = 16'h0000;

    // Tank fluid level low
    alarm1_next[flag_bank_pkg::A1_LOW_TANK] = alarm_cond.low_tank;

    // Channel 1 fluid temperature abnormally high
    alarm1_next[flag_bank_pkg::A1_HIGH_FLUID_TEMP] =
      alarm_cond.high_fluid_temp;

    // Return fluid temperature abnormally high
    alarm1_next[flag_bank_pkg::A1_HIGH_RETURN_TEMP] =
      alarm_cond.high_return_temp;

    // Discharge pressure abnormally high
    alarm1_next[flag_bank_pkg::A1_HIGH_DISCH_PRESS] =
      alarm_cond.high_disch_press;

    // Discharge pressure has risen past its limit
    alarm1_next[flag_bank_pkg::A1_DISCH_PRESS_RISE] =
      alarm_cond.disch_press_rise;

    // Discharge pressure has dropped below its limit
    alarm1_next[flag_bank_pkg::A1_DISCH_PRESS_DROP] =
      alarm_cond.disch_press_drop;

    // Compressor suction temperature abnormally low
    alarm1_next[flag_bank_pkg::A1_LOW_SUCTION_TEMP] =
      alarm_cond.low_suction_temp;

    // High-side refrigerant pressure rise
    alarm1_next[flag_bank_pkg::A1_HS_PRESS_RISE] =
      alarm_cond.hs_press_rise;

    // Refrigerant leak detected
    alarm1_next[flag_bank_pkg::A1_REFRIG_LEAK] =
      alarm_cond.refrig_leak;

    // Low-side refrigerant pressure rise
    alarm1_next[flag_bank_pkg::A1_LS_PRESS_RISE] =
      alarm_cond.ls_press_rise;
  end

  // Alarm word 2 mapping. Bits 3, 4 and 11 to 13 are reserved and read
  // zero; the six sensor failure bits sit in one contiguous run.
  always_comb begin
    // Start from all zero so reserved bits never float
    alarm2_next = 16'h0000;

    // Low-side refrigerant pressure drop
    alarm2_next[flag_bank_pkg::A2_LS_PRESS_DROP] =
      alarm_cond.ls_press_drop;

    // Compressor failed while running
    alarm2_next[flag_bank_pkg::A2_COMP_FAIL] = alarm_cond.comp_fail;

    // Link to the host has failed
    alarm2_next[flag_bank_pkg::A2_COMM_ERROR] =
      alarm_cond.comm_error;

    // Contact inputs 1 and 2 have seen their signal
    alarm2_next[flag_bank_pkg::A2_CONTACT1] = alarm_cond.contact1;
    alarm2_next[flag_bank_pkg::A2_CONTACT2] = alarm_cond.contact2;

    // Sensor failures, in struct order from bit 0 upwards
    for (int i = 0; i < flag_bank_pkg::SENSOR_COUNT; i++) begin
      alarm2_next[flag_bank_pkg::A2_SENSOR_BASE + i] =
        alarm_cond.sensor_fail[i];
    end
  end

  // Mapped words in address order, for the storage loop below
  assign word_next_arr[0] = status_next;
  assign word_next_arr[1] = alarm1_next;
  assign word_next_arr[2] = alarm2_next;

  // Word storage, one register per populated word; a read path exists
  // only, so a write has nowhere to land
  for (genvar w = 0; w < WORD_COUNT; w++) begin : g_word
    flag_word_reg u_word (
      .clk(clk),
      .reset_n(reset_n),
      .word_next(word_next_arr[w]),
      .word_reg(word_arr[w])
    );
  end

  // Names used by the read decode
  assign product_status_word = word_arr[0];
  assign alarm_word_one = word_arr[1];
  assign alarm_word_two = word_arr[2];

  // Address decode. Words 3 to 5 hold alarms kept outside this block,
  // so they answer zero but count as mapped; anything else is refused.
  // The decode reads the stored words, so it lags the inputs one edge.
  always_comb begin
    // Refused, zero answer unless an address below matches
    rd_data_next = 16'h0000;
    rd_hit = 1'b0;
    case (rd_addr)
      // Status word
      flag_bank_pkg::ADDR_STATUS: begin
        rd_data_next = product_status_word;
        rd_hit = 1'b1;
      end
      // First alarm word
      flag_bank_pkg::ADDR_ALARM1: begin
        rd_data_next = alarm_word_one;
        rd_hit = 1'b1;
      end
      // Second alarm word
      flag_bank_pkg::ADDR_ALARM2: begin
        rd_data_next = alarm_word_two;
        rd_hit = 1'b1;
      end
      default: begin
        // Unpopulated words inside the range answer zero
        if (rd_addr >= flag_bank_pkg::ADDR_ALARM3 &&
            rd_addr <= flag_bank_pkg::ADDR_ALARM5) begin
          rd_hit = 1'b1;
        end
      end
    endcase
  end

  // Read answer, registered; one cycle after the strobe. A condition
  // seen at edge N is stored at N, so a strobe taken at N+1 returns it
  // at N+2. The extra stage keeps every answer line on a flip-flop.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Quiet answer port while in reset
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      rd_addr_error <= 1'b0;
    end else begin
      // One pulse per taken strobe; a held strobe reads every cycle
      rd_valid <= rd_strobe;
      // Refusal pulses together with the valid pulse
      rd_addr_error <= rd_strobe && !rd_hit;
      // Hold the last answer between reads so the protocol side can sample
      if (rd_strobe) begin
        rd_data <= rd_data_next;
      end
    end
  end

endmodule : status_alarm_flag_bank

// ==== status_alarm_flag_bank_assertions.sv ====
`timescale 1ns/10ps
// Ties each read answer of the three populated words to the conditions present two edges earlier
module status_alarm_flag_bank_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire flag_bank_pkg::status_cond_t status_cond,
  input wire flag_bank_pkg::alarm_cond_t alarm_cond,
  input wire logic rd_strobe,
  input wire logic [15:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_addr_error
);
  flag_bank_pkg::status_cond_t s; // Short alias
  flag_bank_pkg::alarm_cond_t c; // Short alias
  logic [15:0] st_exp, a1_exp, a2_exp; // Words built from the inputs
  assign s = status_cond;
  assign c = alarm_cond;
  assign st_exp = {s.anti_freeze, 10'h000, s.temp_ready, 1'b0,
    s.cont_alarm, s.stop_alarm, s.running};
  assign a1_exp = {c.ls_press_rise, c.refrig_leak, 1'b0, c.hs_press_rise,
    1'b0, c.low_suction_temp, 1'b0, c.disch_press_drop, c.disch_press_rise,
    1'b0, c.high_disch_press, c.high_return_temp, 2'h0, c.high_fluid_temp,
    c.low_tank};
  assign a2_exp = {c.contact2, c.contact1, 3'h0, c.sensor_fail, 2'h0,
    c.comm_error, c.comp_fail, c.ls_press_drop};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A taken read once the words already hold live data
  sequence rd_of(a);
    rd_strobe && rd_addr == a && $past(reset_n);
  endsequence
  a_valid_after: assert property (rd_strobe |=> rd_valid)
    else $error("read answer missing");
  a_valid_cause: assert property (rd_valid |-> $past(rd_strobe))
    else $error("answer without a read");
  a_bad_addr: assert property (rd_strobe && (rd_addr < 16'h003a ||
    rd_addr > 16'h003f) |=> rd_addr_error && rd_data == 16'h0000)
    else $error("unmapped read not refused");
  a_good_addr: assert property (rd_strobe && rd_addr >= 16'h003a &&
    rd_addr <= 16'h003f |=> !rd_addr_error)
    else $error("mapped read refused");
  a_status_map: assert property (rd_of(16'h003a)
    |=> rd_data == $past(st_exp, 2)) else $error("status word wrong");
  a_alarm1_map: assert property (rd_of(16'h003b)
    |=> rd_data == $past(a1_exp, 2)) else $error("alarm word 1 wrong");
  a_alarm2_map: assert property (rd_of(16'h003c)
    |=> rd_data == $past(a2_exp, 2)) else $error("alarm word 2 wrong");
  a_upper_zero: assert property (rd_strobe && rd_addr >= 16'h003d &&
    rd_addr <= 16'h003f |=> rd_data == 16'h0000)
    else $error("unassigned word not zero");
endmodule : status_alarm_flag_bank_assertions

bind status_alarm_flag_bank status_alarm_flag_bank_assertions chk (
  .clk(clk), .reset_n(reset_n), .status_cond(status_cond),
  .alarm_cond(alarm_cond), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
  .rd_data(rd_data), .rd_valid(rd_valid), .rd_addr_error(rd_addr_error));

// ==== host_reader.sv ====
`timescale 1ns/10ps
// Host side: issues one register read at a time
module host_reader (
  input wire logic clk,
  output logic rd_strobe,
  output logic [15:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_addr_error
);
  initial begin
    rd_strobe = 1'b0;
    rd_addr = 16'h0000;
  end
  // Address is inverted on release so a stale value is never reused
  task rd(input logic [15:0] a, output logic [15:0] d, output logic v,
    output logic e);
    @(posedge clk);
    rd_strobe <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_strobe <= 1'b0;
    rd_addr <= ~a;
    @(negedge clk);
    d = rd_data;
    v = rd_valid;
    e = rd_addr_error;
    @(posedge clk);
  endtask : rd
endmodule : host_reader

// ==== status_alarm_flag_bank_bench.sv ====
`timescale 1ns/10ps
// Walks every condition bit through the read port
module status_alarm_flag_bank_bench;
  logic clk, reset_n, rd_strobe, rd_valid, rd_addr_error, v, e;
  logic [15:0] rd_addr, rd_data, d; // Port wires and read answer
  flag_bank_pkg::status_cond_t sc; // Status conditions
  flag_bank_pkg::alarm_cond_t ac; // Alarm conditions
  int mismatches = 0, n_tests = 0, cycles = 0;
  int spos[5] = '{0, 1, 2, 4, 15}; // Status bit of each condition
  int apos[21] = '{0, 1, 4, 5, 7, 8, 10, 12, 14, 15, 0, 1, 2, 5, 6, 7, 8, 9,
    10, 14, 15}; // Word bit of each alarm, first ten in word 1
  logic [15:0] all[8] = '{16'h0, 16'h8017, 16'hd5b3, 16'hc7e7, 16'h0,
    16'h0, 16'h0, 16'h0}; // Words 0039h..0040h with every condition set
  status_alarm_flag_bank DUT (.clk(clk), .reset_n(reset_n),
    .status_cond(sc), .alarm_cond(ac), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_addr_error(rd_addr_error));
  host_reader host (.clk(clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_addr_error(rd_addr_error));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard, well above the roughly 180 cycles the reads take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      stop_test();
    end
  end
  task chk(string nm, logic [15:0] ex, logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      mismatches++;
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    reset_n = 1'b0;
    sc = '0;
    ac = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      sc <= 5'h01 << i;
      host.rd(16'h003a, d, v, e);
      chk("status", 16'h0001 << spos[i], d);
      chk("valid", 16'h0002, {14'h0, v, e});
    end
    sc <= '0;
    for (int i = 0; i < 21; i++) begin
      ac <= 21'h000001 << i;
      host.rd(16'h003b, d, v, e);
      chk("alarm1", i < 10 ? 16'h1 << apos[i] : 16'h0, d);
      host.rd(16'h003c, d, v, e);
      chk("alarm2", i > 9 ? 16'h0001 << apos[i] : 16'h0, d);
    end
    sc <= '1;
    ac <= '1;
    for (int a = 0; a < 8; a++) begin
      host.rd(16'h0039 + 16'(a), d, v, e);
      chk("word", all[a], d);
      chk("error", {15'h0, a == 0 || a == 7}, {15'h0, e});
    end
    // A second read of a word already read must find it unchanged
    host.rd(16'h003b, d, v, e);
    chk("reread", all[2], d);
    // Mid-run reset clears the answer port, then words refill
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("reset data", 16'h0, rd_data);
    chk("reset flags", 16'h0, {14'h0, rd_valid, rd_addr_error});
    @(posedge clk);
    reset_n <= 1'b1;
    host.rd(16'h003a, d, v, e);
    chk("after reset", all[1], d);
    stop_test();
  end
endmodule : status_alarm_flag_bank_bench
